/* File: bench/lane_receiver.sv */
/*
 * Receiver model for the eight serial lanes: frames on the marker, shifts
 * twelve bits LSB first per lane and counts framing faults.
 * Assumes lanes are launched on link_clk rise, so it samples on the fall.
 */
`timescale 1ns/1ps
module lane_receiver (
   input wire logic link_clk,
   input wire logic [7:0] lane_pos,
   input wire logic [7:0] lane_neg,
   input wire logic bit_clock_out_pos,
   input wire logic bit_clock_out_neg,
   input wire logic frame_marker_pos,
   input wire logic frame_marker_neg,
   output logic [95:0] word_out,
   output int fault_count
);
   logic frame_d = 1'b0;
   logic [95:0] shift = '0;
   int bitn = 12;
   initial word_out = '0;
   initial fault_count = 0;
   always @(negedge link_clk) begin
      if (frame_marker_pos === 1'b1 && frame_d === 1'b0) bitn = 0;
      frame_d = frame_marker_pos;
      // Outputs off show both legs low; no framing to judge then
      if (bitn < 12 && bit_clock_out_pos !== bit_clock_out_neg) begin
         if (bit_clock_out_pos !== (bitn % 2 == 0)) fault_count++;
         if (frame_marker_pos !== (bitn < 6)) fault_count++;
         if (frame_marker_neg !== ~frame_marker_pos) fault_count++;
         if (lane_neg !== ~lane_pos) fault_count++;
         for (int c = 0; c < 8; c++) shift[c*12+bitn] = lane_pos[c];
         if (bitn == 11) word_out = shift;
      end
      if (bitn < 12) bitn++;
   end
endmodule : lane_receiver

/* File: bench/octal_adc_serial_output_test.sv */
/*
 * Self-checking bench: AXI4-Lite register traffic, random samples on all
 * eight channels, and a lane receiver compared with a queue model.
 * Assumes the design, its package and the receiver model compile first.
 */
`timescale 1ns/1ps
module octal_adc_serial_output_test;
   localparam logic [1:0] resp_ok = octal_adc_pkg::RESP_OKAY;
   localparam logic [1:0] resp_err = octal_adc_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic link_clk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic sample_clk = 1'b0;
   logic [95:0] sample_in = '0;
   logic [7:0] lane_pos;
   logic [7:0] lane_neg;
   logic bit_clock_out_pos;
   logic bit_clock_out_neg;
   logic frame_marker_pos;
   logic frame_marker_neg;
   logic [95:0] rx_word;
   logic [95:0] exp_s;
   logic [95:0] r;
   logic [95:0] q[$];
   logic [31:0] seed = 32'h0000_64f1;
   logic [31:0] mode = '0;
   int fault_count;
   int fail_count = 0;
   int checked = 0;
   int skip = 100000;
   int ph = 0;
   int cycles = 0;
   int modes[4] = '{0, 4, 1, 5};

   always #20 aclk = ~aclk;
   // Odd start offset keeps the link edges off the bus edges
   always begin
      #13;
      forever #40 link_clk = ~link_clk;
   end

   octal_adc_serial_output #(.REF_SETTLE_CYCLES(50)) i_octal_adc_serial_output (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .link_clk(link_clk), .sample_clk(sample_clk),
      .sample_in(sample_in), .lane_pos(lane_pos), .lane_neg(lane_neg),
      .bit_clock_out_pos(bit_clock_out_pos), .bit_clock_out_neg(bit_clock_out_neg),
      .frame_marker_pos(frame_marker_pos), .frame_marker_neg(frame_marker_neg));

   lane_receiver i_lane_receiver (
      .link_clk(link_clk), .lane_pos(lane_pos), .lane_neg(lane_neg),
      .bit_clock_out_pos(bit_clock_out_pos), .bit_clock_out_neg(bit_clock_out_neg),
      .frame_marker_pos(frame_marker_pos), .frame_marker_neg(frame_marker_neg),
      .word_out(rx_word), .fault_count(fault_count));

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   function automatic logic [11:0] want_word(input logic [11:0] s);
      if (mode[0])
         return 12'h0bd;
      return mode[2] ? s : s ^ 12'h800;
   endfunction : want_word

   task automatic close_out();
      $display("checked %0d, fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic cmp_bus(input string name, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask : cmp_bus

   task automatic cmp_lane(input string name, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask : cmp_lane

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp_bus("bvalid", 32'h1, {31'h0, s_axi_bvalid});
      cmp_bus("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp_bus("rvalid", 32'h1, {31'h0, s_axi_rvalid});
      cmp_bus("rdata", ed, s_axi_rdata);
      cmp_bus("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : axi_read

   task automatic set_mode(input logic [31:0] m);
      mode = m;
      skip = 10;
      axi_write(8'h00, m, resp_ok);
   endtask : set_mode

   // Sample clock is twelve link periods; samples change mid-period, away from the rise
   always @(posedge link_clk) begin
      ph = (ph + 1) % 12;
      sample_clk <= (ph < 6);
      if (ph == 6) begin
         seed = xs(seed);
         r[31:0] = seed;
         seed = xs(seed);
         r[63:32] = seed;
         seed = xs(seed);
         r[95:64] = seed;
         sample_in <= r;
      end
      if (ph == 0) begin
         if (q.size() == 8) begin
            exp_s = q.pop_front();
            if (skip == 0 && mode[1] == 1'b0) begin
               for (int c = 0; c < 8; c++) begin
                  cmp_lane("lane word", want_word(exp_s[c*12+:12]), rx_word[c*12+:12]);
               end
            end
         end
         q.push_back(sample_in);
         if (skip > 0) skip--;
      end
   end

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (200) @(posedge aclk);
      skip = 10;
      axi_read(8'h00, 32'h0, resp_ok);
      axi_read(8'h04, 32'h3, resp_ok);
      axi_read(8'h08, 32'h0, resp_err);
      axi_write(8'h08, 32'hffff_ffff, resp_err);
      axi_write(8'h04, 32'h0000_0007, resp_ok);
      axi_read(8'h04, 32'h3, resp_ok);
      for (int k = 0; k < 8; k++) begin
         axi_write(8'h00, 32'(k) << 4, resp_ok);
         axi_read(8'h00, 32'(k) << 4, resp_ok);
      end
      foreach (modes[i]) begin
         set_mode(32'(modes[i]));
         repeat (480) @(posedge aclk);
      end
      set_mode(32'h2);
      repeat (40) @(posedge aclk);
      cmp_bus("idle link", 32'h0, {12'h0, lane_pos, lane_neg, bit_clock_out_pos,
         bit_clock_out_neg, frame_marker_pos, frame_marker_neg});
      axi_read(8'h04, 32'h4, resp_ok);
      set_mode(32'h4);
      repeat (480) @(posedge aclk);
      axi_read(8'h04, 32'h3, resp_ok);
      cmp_bus("link faults", 32'h0, fault_count);
      close_out();
   end
endmodule : octal_adc_serial_output_test

/* File: src/octal_adc_defs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * eight-lane serial converter output block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef OCTAL_ADC_DEFS_SVH
`define OCTAL_ADC_DEFS_SVH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04

`define CTRL_TEST_BIT 0
`define CTRL_PD_BIT 1
`define CTRL_FMT_BIT 2
`define CTRL_PLL_LSB 4
`define CTRL_RESET 32'h0000_0000

`define STATUS_LOCK_BIT 0
`define STATUS_REF_BIT 1
`define STATUS_PD_BIT 2

`define TEST_WORD 12'h0bd
`define TWOS_FLIP 12'h800

`define LINK_PER_SAMPLE 4'hc
`define HALF_SAMPLE 4'h6
`define LAST_PHASE 4'hb
`define PIPE_STAGES 13

`define AXI_CLK_HZ 25000000
`define REF_SETTLE_MS 100
`define REF_SETTLE_CYCLES (`REF_SETTLE_MS * (`AXI_CLK_HZ / 1000))

`endif

/* File: src/octal_adc_pkg.sv */
/*
 * Types shared by the serial converter output block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package octal_adc_pkg;

   typedef logic [3:0] phase_t;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_t;

   typedef enum logic [1:0] {
      SEL_CTRL = 2'h0,
      SEL_STATUS = 2'h1,
      SEL_NONE = 2'h2
   } reg_sel_t;

endpackage : octal_adc_pkg

/* File: src/octal_adc_serial_output.sv */
/*
 * Output side of an eight-channel 12-bit converter: sample capture, half-cycle
 * pipeline, formatting, LSB-first lane serialisers, bit clock and frame marker,
 * with an AXI4-Lite control slave on aclk.
 * Assumes link_clk runs at twelve times the sample rate and that sample_clk is
 * generated from it, and that sample_in is stable around each sample_clk rise.
 */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "octal_adc_defs.svh"

// Overview of operation
// - With the test pattern enabled every lane sends word 0x0bd, LSB first.
// - With the test pattern disabled the lanes send the conversion results.
// - Power-down stops all channels and the reference; clear runs normally.
// - Format select high gives offset binary, low gives two's complement.
// - Each result starts on the lanes 6.5 sample periods after its capture edge.
// - The pipeline moves every sample one stage each half sample period.
// - Eight channels sample together and share one bit clock and frame marker.
// - Samples are taken on the rising edge of the external sample clock.
// - The bit clock runs at six times the sample rate and paces the lanes.
// - Each channel drives its result onto its own differential lane.
// - Lane bits change on both bit clock edges, LSB first, twelve per sample.
// - The frame marker runs at the sample rate and rises with bit 0.
module octal_adc_serial_output #(
   parameter int CHANNELS = 8,
   parameter int WORD_BITS = 12,
   parameter int unsigned REF_SETTLE_CYCLES = `REF_SETTLE_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_clk,
   input wire logic sample_clk,
   input wire logic [CHANNELS*WORD_BITS-1:0] sample_in,
   output logic [CHANNELS-1:0] lane_pos,
   output logic [CHANNELS-1:0] lane_neg,
   output logic bit_clock_out_pos,
   output logic bit_clock_out_neg,
   output logic frame_marker_pos,
   output logic frame_marker_neg
);

   typedef logic [CHANNELS-1:0][WORD_BITS-1:0] word_set_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic serial_test_pattern_enable;
      logic power_down_input;
      logic format_offset_binary;
      logic [2:0] pll_range;
      logic [2:0] lock_s, pd_s;
      logic lock_f, pd_f;
      logic [31:0] settle_cnt;
      logic ref_ready;
   } sys_t;

   typedef struct packed {
      logic [2:0] rst_s, clk_s, te_s, pd_s, fmt_s;
      logic rst_f, clk_f, te_f, pd_f, fmt_f;
      logic locked;
      octal_adc_pkg::phase_t phase;
      logic [`PIPE_STAGES-1:0][CHANNELS-1:0][WORD_BITS-1:0] pipe;
      word_set_t shreg;
      logic [CHANNELS-1:0] lane;
      logic [CHANNELS-1:0] lane_n;
      logic bclk;
      logic bclk_n;
      logic frame;
      logic frame_n;
   } link_t;

   sys_t s_r, s_nxt;
   link_t l_r, l_nxt;
   logic rise, tick, load, en, halt;
   octal_adc_pkg::phase_t cur;

   // Level passes once the second and third flops agree
   function automatic logic agree(input logic [2:0] sync, input logic held);
      agree = (sync[1] == sync[2]) ? sync[2] : held;
   endfunction : agree

   function automatic octal_adc_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
      if ({addr[7:2], 2'h0} == `ADDR_CTRL)
         reg_sel = octal_adc_pkg::SEL_CTRL;
      else if ({addr[7:2], 2'h0} == `ADDR_STATUS)
         reg_sel = octal_adc_pkg::SEL_STATUS;
      else
         reg_sel = octal_adc_pkg::SEL_NONE;
   endfunction : reg_sel

   function automatic logic [WORD_BITS-1:0] fmt_word(input logic [WORD_BITS-1:0] d,
         input logic te, input logic offset_bin);
      if (te)
         fmt_word = WORD_BITS'(`TEST_WORD);
      else if (offset_bin)
         fmt_word = d;
      else
         fmt_word = d ^ WORD_BITS'(`TWOS_FLIP);
   endfunction : fmt_word

   // Register side
   always_comb begin
      logic [31:0] rd;
      rd = '0;
      s_nxt = s_r;
      s_nxt.lock_s = {s_r.lock_s[1:0], l_r.locked};
      s_nxt.pd_s = {s_r.pd_s[1:0], l_r.pd_f};
      s_nxt.lock_f = agree(s_r.lock_s, s_r.lock_f);
      s_nxt.pd_f = agree(s_r.pd_s, s_r.pd_f);
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;
      if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
         s_nxt.bresp = octal_adc_pkg::RESP_OKAY;
         if (reg_sel(s_nxt.aw_addr) == octal_adc_pkg::SEL_CTRL) begin
            if (s_nxt.w_strb[0]) begin
               s_nxt.serial_test_pattern_enable = s_nxt.w_data[`CTRL_TEST_BIT];
               s_nxt.power_down_input = s_nxt.w_data[`CTRL_PD_BIT];
               s_nxt.format_offset_binary = s_nxt.w_data[`CTRL_FMT_BIT];
               s_nxt.pll_range = s_nxt.w_data[`CTRL_PLL_LSB +: 3];
            end
         end else if (reg_sel(s_nxt.aw_addr) == octal_adc_pkg::SEL_NONE) begin
            s_nxt.bresp = octal_adc_pkg::RESP_SLVERR;
         end
         s_nxt.bvalid = 1'b1;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = octal_adc_pkg::RESP_OKAY;
         unique case (reg_sel(s_axi_araddr))
            octal_adc_pkg::SEL_CTRL: begin
               rd[`CTRL_TEST_BIT] = s_r.serial_test_pattern_enable;
               rd[`CTRL_PD_BIT] = s_r.power_down_input;
               rd[`CTRL_FMT_BIT] = s_r.format_offset_binary;
               rd[`CTRL_PLL_LSB +: 3] = s_r.pll_range;
            end
            octal_adc_pkg::SEL_STATUS: begin
               rd[`STATUS_LOCK_BIT] = s_r.lock_f;
               rd[`STATUS_REF_BIT] = s_r.ref_ready;
               rd[`STATUS_PD_BIT] = s_r.pd_f;
            end
            default: s_nxt.rresp = octal_adc_pkg::RESP_SLVERR;
         endcase
         s_nxt.rdata = rd;
      end
      // Settling timer restarts on power-up and on power-down release
      if (s_r.power_down_input) begin
         s_nxt.settle_cnt = '0;
         s_nxt.ref_ready = 1'b0;
      end else if (s_r.settle_cnt < 32'(REF_SETTLE_CYCLES)) begin
         s_nxt.settle_cnt = s_r.settle_cnt + 32'h1;
      end else begin
         s_nxt.ref_ready = 1'b1;
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
      s_nxt.arready = !s_nxt.rvalid;
      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.serial_test_pattern_enable = 1'(`CTRL_RESET >> `CTRL_TEST_BIT);
         s_nxt.power_down_input = 1'(`CTRL_RESET >> `CTRL_PD_BIT);
         s_nxt.format_offset_binary = 1'(`CTRL_RESET >> `CTRL_FMT_BIT);
         s_nxt.pll_range = 3'(`CTRL_RESET >> `CTRL_PLL_LSB);
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   // Link side; phase re-locks to each filtered sample clock rise
   assign rise = (l_r.clk_s[2:1] == 2'h3) && !l_r.clk_f;
   assign cur = rise ? 4'h0 : l_r.phase;
   assign tick = (cur == 4'h0) || (cur == `HALF_SAMPLE);
   assign load = (cur == `HALF_SAMPLE);
   assign en = l_r.locked && !l_r.pd_f;
   assign halt = !l_r.rst_f || l_r.pd_f; // Power-down may cut a word short

   always_comb begin
      l_nxt = l_r;
      l_nxt.rst_s = {l_r.rst_s[1:0], aresetn};
      l_nxt.clk_s = {l_r.clk_s[1:0], sample_clk};
      l_nxt.te_s = {l_r.te_s[1:0], s_r.serial_test_pattern_enable};
      l_nxt.pd_s = {l_r.pd_s[1:0], s_r.power_down_input};
      l_nxt.fmt_s = {l_r.fmt_s[1:0], s_r.format_offset_binary};
      l_nxt.rst_f = agree(l_r.rst_s, l_r.rst_f);
      l_nxt.clk_f = agree(l_r.clk_s, l_r.clk_f);
      l_nxt.te_f = agree(l_r.te_s, l_r.te_f);
      l_nxt.pd_f = agree(l_r.pd_s, l_r.pd_f);
      l_nxt.fmt_f = agree(l_r.fmt_s, l_r.fmt_f);
      l_nxt.phase = (cur == `LAST_PHASE) ? 4'h0 : cur + 4'h1;
      if (rise)
         l_nxt.locked = 1'b1;
      if (tick) begin
         for (int i = 1; i < `PIPE_STAGES; i++)
            l_nxt.pipe[i] = l_r.pipe[i-1];
         l_nxt.pipe[0] = (cur == 4'h0) ? sample_in : '0;
      end
      for (int c = 0; c < CHANNELS; c++) begin
         if (load) begin
            l_nxt.shreg[c] = fmt_word(l_r.pipe[`PIPE_STAGES-1][c], l_r.te_f, l_r.fmt_f);
            l_nxt.lane[c] = en && l_nxt.shreg[c][0];
            l_nxt.shreg[c] = l_nxt.shreg[c] >> 1;
         end else begin
            l_nxt.lane[c] = en && l_r.shreg[c][0];
            l_nxt.shreg[c] = l_r.shreg[c] >> 1;
         end
      end
      l_nxt.lane_n = en ? ~l_nxt.lane : '0;
      l_nxt.frame = en && (cur >= `HALF_SAMPLE);
      l_nxt.frame_n = en && !l_nxt.frame;
      l_nxt.bclk = en && !cur[0];
      l_nxt.bclk_n = en && !l_nxt.bclk;
      // Power-down drops lock and flushes the pipeline
      if (l_r.pd_f) begin
         l_nxt.locked = 1'b0;
         l_nxt.pipe = '0;
         l_nxt.shreg = '0;
      end
      if (!l_r.rst_f) begin
         l_nxt.locked = 1'b0;
         l_nxt.phase = '0;
         l_nxt.pipe = '0;
         l_nxt.shreg = '0;
         l_nxt.lane = '0;
         l_nxt.lane_n = '0;
         l_nxt.bclk = 1'b0;
         l_nxt.bclk_n = 1'b0;
         l_nxt.frame = 1'b0;
         l_nxt.frame_n = 1'b0;
      end
   end

   always_ff @(posedge link_clk) begin
      l_r <= l_nxt;
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rdata = s_r.rdata;
   assign lane_pos = l_r.lane;
   assign lane_neg = l_r.lane_n;
   assign bit_clock_out_pos = l_r.bclk;
   assign bit_clock_out_neg = l_r.bclk_n;
   assign frame_marker_pos = l_r.frame;
   assign frame_marker_neg = l_r.frame_n;

   sequence test_bits;
      l_r.lane[0] ##1 !l_r.lane[0] ##1 l_r.lane[0] ##1 l_r.lane[0] ##1 l_r.lane[0]
         ##1 l_r.lane[0] ##1 !l_r.lane[0] ##1 l_r.lane[0] ##1 !l_r.lane[0][*4];
   endsequence

   a_test_word: assert property (@(posedge link_clk) disable iff (halt)
      (load && en && l_r.te_f && !l_nxt.pd_f) |=> test_bits)
      else $error("test pattern not sent");
   a_offset_binary: assert property (@(posedge link_clk) disable iff (halt)
      (load && en && !l_r.te_f && l_r.fmt_f) |=>
      (l_r.lane[0] == $past(l_r.pipe[`PIPE_STAGES-1][0][0]))
      ##11 (l_r.lane[0] == $past(l_r.pipe[`PIPE_STAGES-1][0][WORD_BITS-1], 12)))
      else $error("offset binary word wrong");
   a_twos_msb: assert property (@(posedge link_clk) disable iff (halt)
      (load && en && !l_r.te_f && !l_r.fmt_f && !l_nxt.pd_f) |=> ##11
      (l_r.lane[0] == !$past(l_r.pipe[`PIPE_STAGES-1][0][WORD_BITS-1], 12)))
      else $error("two's complement msb not inverted");
   a_power_off: assert property (@(posedge link_clk) disable iff (!l_r.rst_f)
      l_r.pd_f |=> (l_r.lane == '0) && !l_r.frame && !l_r.bclk && !l_r.locked)
      else $error("outputs active in power-down");
   a_sample_latency: assert property (@(posedge link_clk) disable iff (halt)
      (rise && l_r.locked && !l_r.pd_f) |-> ##79 (l_r.pd_f || $rose(l_r.frame)))
      else $error("result not 6.5 periods after capture");
   a_pipe_step: assert property (@(posedge link_clk) disable iff (!l_r.rst_f)
      (tick && !l_r.pd_f) |=> (l_r.pipe[1] == $past(l_r.pipe[0])))
      else $error("pipeline did not advance");
   a_frame_shape: assert property (@(posedge link_clk) disable iff (halt)
      ($rose(l_r.frame) && en) |-> $past(load) ##0 (l_r.frame[*6] ##1 !l_r.frame))
      else $error("frame marker misaligned");
   a_bit_clock: assert property (@(posedge link_clk) disable iff (!l_r.rst_f)
      ($rose(l_r.frame) && l_nxt.locked && !l_r.pd_f) |-> l_r.bclk ##1 !l_r.bclk)
      else $error("bit clock not aligned to frame");
   a_lane_pair: assert property (@(posedge link_clk) disable iff (!l_r.rst_f)
      en |=> (l_r.lane_n == ~l_r.lane))
      else $error("lane pair not complementary");
   a_capture_all: assert property (@(posedge link_clk) disable iff (!l_r.rst_f)
      (rise && !l_r.pd_f) |=> (l_r.pipe[0] == $past(sample_in)))
      else $error("channels not captured together");
   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_r.awready && s_axi_wvalid && s_r.wready) |=> s_r.bvalid)
      else $error("write not answered");

endmodule : octal_adc_serial_output
